// ===== core/itdc_top.sv
/*
  forwarding control, bus timing and datapath option registers.
  assumes an already decoded byte register port from the local bus
  target logic, and bus pins arriving asynchronously.
*/
`timescale 1ns/1ns
`include "itdc_defs.svh"
module itdc_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic second_port_select,
  input wire logic aux_audio_control,
  input wire logic [6:0] access_target_id,
  input wire logic access_valid,
  input wire logic [6:0] own_target_id,
  input wire logic [6:0] remote_deser_id,
  input wire logic [6:0] remote_target_id,
  output logic forward_port0,
  output logic forward_port1,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_sampled,
  output logic scl_filtered,
  input wire logic master_active,
  output logic master_scl_drive,
  input wire logic target_stretch_req,
  output logic target_scl_release,
  output logic wide_payload_select,
  input wire logic inband_surround_detect,
  input wire logic inband_override_disable,
  output logic surround_enable,
  output logic data_island_transport
);
  // ****************************************
  // storage
  // ****************************************
  // pass-all is kept per port; hold and filter are shared by both
  // ports, so only bit 7 of the control register is steered
  logic pass_all_p0; // port 0 pass-all
  logic pass_all_p1; // port 1 pass-all
  logic [2:0] hold_field; // sda hold in 40ns units
  logic [3:0] filter_field; // glitch depth in 5ns units
  logic [7:0] high_time; // master high count
  logic [7:0] low_time; // master low count
  logic wide_bit; // payload width
  logic surround_bit; // software surround enable

  // ****************************************
  // register decode
  // ****************************************
  // full byte compare, so aliases of the four offsets read zero
  wire hit_fwd = reg_addr == `ITDC_OFF_FWD_CTRL;
  wire hit_high = reg_addr == `ITDC_OFF_HIGH_TIME;
  wire hit_low = reg_addr == `ITDC_OFF_LOW_TIME;
  wire hit_dp = reg_addr == `ITDC_OFF_DP_CTRL2;
  // pass-all shown is the one for the selected port
  wire pass_all_view = second_port_select ? pass_all_p1 : pass_all_p0;
  wire [7:0] fwd_view = {pass_all_view, hold_field, filter_field};
  // reserved bits 7:4 and 2 read zero
  wire [7:0] dp_view = {4'h0, aux_audio_control, 1'b0, wide_bit, surround_bit};
  wire [7:0] next_rdata = hit_fwd ? fwd_view :
                          hit_high ? high_time :
                          hit_low ? low_time :
                          hit_dp ? dp_view : `ITDC_ZERO8;

  // ****************************************
  // register writes
  // ****************************************
  // a write lands on the edge that samples reg_write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pass_all_p0 <= 1'(`ITDC_RST_FWD_CTRL >> `ITDC_BIT_PASS_ALL);
      pass_all_p1 <= 1'(`ITDC_RST_FWD_CTRL >> `ITDC_BIT_PASS_ALL);
      hold_field <= 3'(`ITDC_RST_FWD_CTRL >> `ITDC_HOLD_LO);
      filter_field <= 4'(`ITDC_RST_FWD_CTRL);
      high_time <= `ITDC_RST_HIGH_TIME;
      low_time <= `ITDC_RST_LOW_TIME;
      {wide_bit, surround_bit} <= `ITDC_RST_DP_BITS;
    end else if (reg_write) begin
      if (hit_fwd) begin
        if (second_port_select) begin
          pass_all_p1 <= reg_wdata[`ITDC_BIT_PASS_ALL];
        end else begin
          pass_all_p0 <= reg_wdata[`ITDC_BIT_PASS_ALL];
        end
        hold_field <= reg_wdata[`ITDC_HOLD_HI:`ITDC_HOLD_LO];
        filter_field <= reg_wdata[`ITDC_FILT_HI:`ITDC_FILT_LO];
      end
      if (hit_high) begin
        high_time <= reg_wdata;
      end
      if (hit_low) begin
        low_time <= reg_wdata;
      end
      if (hit_dp) begin
        // read-only and reserved bits dropped
        wide_bit <= reg_wdata[`ITDC_BIT_WIDE];
        surround_bit <= reg_wdata[`ITDC_BIT_SURR];
      end
    end
  end

  // read data registered; held between reads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= `ITDC_ZERO8;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // forwarding decision
  // ****************************************
  wire remote_hit = access_target_id == remote_deser_id || access_target_id == remote_target_id;
  wire not_own = access_target_id != own_target_id;
  // pass-all widens to every id but our own
  wire fwd0 = access_valid && (pass_all_p0 ? not_own : remote_hit);
  wire fwd1 = access_valid && (pass_all_p1 ? not_own : remote_hit);

  // registered so a changing id never glitches the forward request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      forward_port0 <= 1'b0;
      forward_port1 <= 1'b0;
    end else begin
      forward_port0 <= fwd0;
      forward_port1 <= fwd1;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] scl_sync; // bit 0 only feeds bit 1
  logic [1:0] sda_sync;
  // pins are asynchronous; two flops before anything reads them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_pin};
      sda_sync <= {sda_sync[0], sda_pin};
    end
  end

  // ****************************************
  // glitch filter and sda hold
  // ****************************************
  // filter depth in cycles; below one clock it is zero, which still rejects one-cycle pulses
  wire [7:0] filt_cycles = 8'((32'(filter_field) * `ITDC_FILT_UNIT_PS) / `ITDC_CLK_PS);
  // hold delay in cycles, rounded up so the hold is never short
  wire [7:0] hold_cycles = 8'((32'(hold_field) * `ITDC_HOLD_UNIT_PS + `ITDC_CLK_PS - 1)
                              / `ITDC_CLK_PS);
  // both lines share one depth so scl and sda stay aligned
  logic scl_clean;
  logic sda_clean;
  itdc_filter u_scl_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .line_in(scl_sync[1]),
    .depth(filt_cycles),
    .line_out(scl_clean)
  );
  itdc_filter u_sda_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .line_in(sda_sync[1]),
    .depth(filt_cycles),
    .line_out(sda_clean)
  );

  // sda delay line, eight taps covers the 3-bit field at 10 MHz
  // only taps 0 to 2 are reached while one clock spans 2.5 counts
  logic [7:0] sda_delay;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sda_delay <= 8'hff;
      sda_sampled <= 1'b1;
      scl_filtered <= 1'b1;
    end else begin
      sda_delay <= {sda_delay[6:0], sda_clean};
      scl_filtered <= scl_clean;
      sda_sampled <= (hold_cycles == `ITDC_ZERO8) ? sda_clean
                     : sda_delay[3'(hold_cycles - `ITDC_ONE)];
    end
  end

  // ****************************************
  // master clock generator
  // ****************************************
  // one count is one clock here; at 10 MHz the 40 ns unit cannot be
  // resolved, so times stretch but keep their count-plus-five shape
  itdc_pkg::itdc_phase_type phase;
  itdc_pkg::itdc_phase_type next_phase;
  logic [8:0] phase_count;
  wire [8:0] high_limit = {1'b0, high_time} + {1'b0, `ITDC_EXTRA_PERIODS};
  wire [8:0] low_limit = {1'b0, low_time} + {1'b0, `ITDC_EXTRA_PERIODS};
  wire high_done = phase_count + 9'h001 >= high_limit;
  wire low_done = phase_count + 9'h001 >= low_limit;

  // a dropped request lets the running phase finish before idle
  always_comb begin
    next_phase = phase;
    unique case (phase)
      itdc_pkg::itdc_idle: begin
        if (master_active) begin
          next_phase = itdc_pkg::itdc_low;
        end
      end
      itdc_pkg::itdc_low: begin
        if (low_done) begin
          next_phase = master_active ? itdc_pkg::itdc_high : itdc_pkg::itdc_idle;
        end
      end
      itdc_pkg::itdc_high: begin
        if (high_done) begin
          next_phase = master_active ? itdc_pkg::itdc_low : itdc_pkg::itdc_idle;
        end
      end
      default: begin
        next_phase = itdc_pkg::itdc_idle; // code 2 is illegal
      end
    endcase
  end

  // drive mirrors the registered phase, so it needs no extra stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= itdc_pkg::itdc_idle;
      phase_count <= 9'h000;
      master_scl_drive <= 1'b0;
    end else begin
      phase <= next_phase;
      phase_count <= (next_phase != phase) ? 9'h000 : phase_count + 9'h001;
      master_scl_drive <= next_phase == itdc_pkg::itdc_low; // pull low
    end
  end

  // ****************************************
  // target setup before releasing a stretch
  // ****************************************
  logic [8:0] setup_count; // cycles of data setup so far
  // release is held off for low_time cycles after a stretch request;
  // a zero count releases at once, trading setup for speed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      setup_count <= 9'h000;
      target_scl_release <= 1'b1;
    end else if (!target_stretch_req) begin
      setup_count <= 9'h000;
      target_scl_release <= 1'b1;
    end else if (setup_count < {1'b0, low_time}) begin
      setup_count <= setup_count + 9'h001; // data driven, still holding
      target_scl_release <= 1'b0;
    end else begin
      target_scl_release <= 1'b1;
    end
  end

  // ****************************************
  // datapath options
  // ****************************************
  // outputs are registered copies so the datapath sees clean levels
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wide_payload_select <= 1'b0;
      surround_enable <= 1'b0;
      data_island_transport <= 1'b0;
    end else begin
      wide_payload_select <= wide_bit;
      // in-band detection wins unless explicitly disabled
      surround_enable <= inband_override_disable ? surround_bit
                         : inband_surround_detect;
      data_island_transport <= inband_override_disable ? surround_bit
                               : inband_surround_detect;
    end
  end
endmodule

// ===== core/itdc_defs.svh
/*
  constants for the forwarding, bus timing and datapath registers.
  assumes it is included by its bare name from files under core/.
*/
`ifndef ITDC_DEFS_SVH
`define ITDC_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define ITDC_OFF_FWD_CTRL 8'h17
`define ITDC_OFF_HIGH_TIME 8'h18
`define ITDC_OFF_LOW_TIME 8'h19
`define ITDC_OFF_DP_CTRL2 8'h1a

// ****************************************
// reset values
// ****************************************
`define ITDC_RST_FWD_CTRL 8'h1e
`define ITDC_RST_HIGH_TIME 8'h7f
`define ITDC_RST_LOW_TIME 8'h7f
`define ITDC_RST_DP_BITS 2'h0

// ****************************************
// field positions
// ****************************************
`define ITDC_BIT_PASS_ALL 7
`define ITDC_HOLD_HI 6
`define ITDC_HOLD_LO 4
`define ITDC_FILT_HI 3
`define ITDC_FILT_LO 0
`define ITDC_BIT_AUX 3
`define ITDC_BIT_WIDE 1
`define ITDC_BIT_SURR 0

// ****************************************
// timing: units in ps, clock period in ps
// ****************************************
`define ITDC_CLK_PS 100000
`define ITDC_HOLD_UNIT_PS 40000
`define ITDC_FILT_UNIT_PS 5000
`define ITDC_EXTRA_PERIODS 8'h05
`define ITDC_ONE 8'h01
`define ITDC_ZERO8 8'h00

`endif

// ===== core/itdc_pkg.sv
/*
  types for the forwarding and timing register block.
  assumes nothing of its surroundings.
*/
package itdc_pkg;
  // master clock phase, gray coded
  typedef enum logic [1:0] {
    itdc_idle = 2'h0,
    itdc_low = 2'h1,
    itdc_high = 2'h3
  } itdc_phase_type;
endpackage

// ===== core/itdc_filter.sv
/*
  glitch filter with delay for one bus line.
  assumes the input is already synchronised to clk_sys.
*/
`timescale 1ns/1ns
`include "itdc_defs.svh"
module itdc_filter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic line_in,
  input wire logic [7:0] depth,
  output logic line_out
);
  logic [7:0] stable_count; // cycles the candidate value has held
  logic candidate; // last raw value seen

  // ****************************************
  // accept a new level only once it outlasts depth
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      candidate <= 1'b1;
      stable_count <= `ITDC_ZERO8;
      line_out <= 1'b1;
    end else if (line_in != candidate) begin
      candidate <= line_in;
      stable_count <= `ITDC_ZERO8;
    end else if (stable_count >= depth) begin
      line_out <= candidate; // held longer than a glitch
    end else begin
      stable_count <= stable_count + `ITDC_ONE;
    end
  end
endmodule

// ===== dv/itdc_props.sv
/*
  port-level checker for itdc_top: forwarding, bus timing, read-back.
  assumes it is bound to every itdc_top instance.
*/
`timescale 1ns/1ns
module itdc_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic aux_audio_control,
  input wire logic [6:0] access_target_id,
  input wire logic access_valid,
  input wire logic [6:0] own_target_id,
  input wire logic [6:0] remote_deser_id,
  input wire logic [6:0] remote_target_id,
  input wire logic forward_port0,
  input wire logic forward_port1,
  input wire logic scl_pin,
  input wire logic scl_filtered,
  input wire logic master_active,
  input wire logic master_scl_drive,
  input wire logic inband_surround_detect,
  input wire logic inband_override_disable,
  input wire logic surround_enable
);
  // ********
  // helpers
  // ********
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // id matches one of the two remote ids
  wire is_rem = (access_target_id == remote_deser_id) || (access_target_id == remote_target_id);
  wire is_own = access_target_id == own_target_id; // own id, forwarded only when it is also a remote id and pass-all is off
  wire in_map = reg_addr >= 8'h17 && reg_addr <= 8'h1a; // mapped window
  a_fwd_idle_none: assert property (!access_valid |=> !forward_port0 && !forward_port1)
    else $error("forward without access");
  a_fwd_remote_pass: assert property (access_valid && is_rem && !is_own |=> forward_port0 && forward_port1)
    else $error("remote id not forwarded");
  a_fwd_own_block: assert property (access_valid && is_own && !is_rem |=> !forward_port0 && !forward_port1)
    else $error("own id forwarded");
  // both phases last at least the five extra periods
  a_low_phase_min: assert property ($rose(master_scl_drive) |-> master_scl_drive[*5])
    else $error("low phase too short");
  a_high_phase_min: assert property ($fell(master_scl_drive) && $past(master_active) |-> !master_scl_drive[*5])
    else $error("high phase too short");
  a_scl_high_pass: assert property (scl_pin[*8] |-> scl_filtered)
    else $error("steady high lost");
  a_scl_low_pass: assert property ((!scl_pin)[*8] |-> !scl_filtered)
    else $error("steady low lost");
  a_rd_unmapped: assert property (reg_read && !in_map |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rd_reserved: assert property (reg_read && reg_addr == 8'h1a |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[2])
    else $error("reserved bits not zero");
  a_aux_mirror: assert property (reg_read && reg_addr == 8'h1a |=> reg_rdata[3] == $past(aux_audio_control))
    else $error("aux bit not mirrored");
  a_surr_follow: assert property (!inband_override_disable |=> surround_enable == $past(inband_surround_detect))
    else $error("in-band detect ignored");
  c_fwd_split: cover property (forward_port0 && !forward_port1);
  c_low_end: cover property ($fell(master_scl_drive));
  c_surround: cover property (surround_enable);
endmodule
bind itdc_top itdc_props i_itdc_props (.clk_sys, .rst, .reg_addr, .reg_read, .reg_rdata,
  .aux_audio_control, .access_target_id, .access_valid, .own_target_id, .remote_deser_id,
  .remote_target_id, .forward_port0, .forward_port1, .scl_pin, .scl_filtered, .master_active,
  .master_scl_drive, .inband_surround_detect, .inband_override_disable, .surround_enable);

// ===== dv/itdc_bus_model.sv
/*
  local bus wires: open-drain scl and sda with pull-ups.
  assumes the bench pulls lines low in the host's place.
*/
`timescale 1ns/1ns
module itdc_bus_model (
  input wire logic master_scl_drive,
  input wire logic host_scl_low,
  input wire logic host_sda_low,
  output logic scl_pin,
  output logic sda_pin
);
  // wired-and: any party pulling low wins, else pull-up
  assign scl_pin = !(master_scl_drive || host_scl_low);
  assign sda_pin = !host_sda_low; // released line floats high
endmodule

// ===== dv/test_itdc_top.sv
/*
  self-checking bench for itdc_top.
  assumes the bus model supplies the pin levels.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_itdc_top;
  logic clk_sys, rst, reg_write, reg_read, access_valid, master_active, target_stretch_req;
  logic aux_audio_control, second_port_select, inband_surround_detect, inband_override_disable;
  logic host_scl_low, host_sda_low, scl_pin, sda_pin, forward_port0, forward_port1;
  logic sda_sampled, scl_filtered, master_scl_drive, target_scl_release;
  logic wide_payload_select, surround_enable, data_island_transport;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] access_target_id, own_target_id, remote_deser_id, remote_target_id;
  int bad_count, checks_done, cyc, n;
  itdc_top i_itdc_top (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .second_port_select, .aux_audio_control, .access_target_id, .access_valid, .own_target_id,
    .remote_deser_id, .remote_target_id, .forward_port0, .forward_port1, .scl_pin, .sda_pin,
    .sda_sampled, .scl_filtered, .master_active, .master_scl_drive, .target_stretch_req,
    .target_scl_release, .wide_payload_select, .inband_surround_detect,
    .inband_override_disable, .surround_enable, .data_island_transport);
  itdc_bus_model i_itdc_bus_model (.master_scl_drive, .host_scl_low, .host_sda_low, .scl_pin,
    .sda_pin);
  // ********
  // clock, watchdog, bus tasks
  // ********
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // cut a hang short well past the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  // all bus tasks start and end 5 ns after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    @(posedge clk_sys);
    #5 reg_write = 0;
    // spare edge: a following call never re-raises a strobe in one step
    @(posedge clk_sys);
    #5;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_read = 1;
    @(posedge clk_sys);
    #5 reg_read = 0;
    `CHK("reg_rdata", e, reg_rdata)
    @(posedge clk_sys);
    #5;
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge clk_sys);
    #5;
  endtask
  // cycles a line stays at one level, bounded
  task automatic span(ref logic s, input logic want, output int k);
    k = 0;
    while (s === want && k < 300) begin
      @(posedge clk_sys);
      #5 k++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset_vals();
    rdchk(8'h17, 8'h1e);
    rdchk(8'h18, 8'h7f);
    rdchk(8'h19, 8'h7f);
    rdchk(8'h1a, 8'h08);
    rdchk(8'h30, 8'h00);
    $display("test reset_vals done");
  endtask
  task automatic t_fwd();
    wr(8'h17, 8'h9e);
    second_port_select = 1;
    rdchk(8'h17, 8'h1e);
    second_port_select = 0;
    rdchk(8'h17, 8'h9e);
    access_target_id = 7'h33;
    access_valid = 1;
    wait_n(2);
    `CHK("forward_port0", 1'b1, forward_port0)
    `CHK("forward_port1", 1'b0, forward_port1)
    access_target_id = own_target_id;
    wait_n(2);
    `CHK("forward_port0", 1'b0, forward_port0)
    access_target_id = remote_deser_id;
    wait_n(2);
    `CHK("forward_port1", 1'b1, forward_port1)
    second_port_select = 1;
    wr(8'h17, 8'h9e);
    second_port_select = 0;
    access_target_id = 7'h33;
    wait_n(2);
    `CHK("forward_port1", 1'b1, forward_port1)
    access_valid = 0;
    $display("test fwd done");
  endtask
  task automatic t_dp();
    wr(8'h1a, 8'hff);
    rdchk(8'h1a, 8'h0b);
    inband_override_disable = 1;
    wait_n(3);
    `CHK("wide_payload_select", 1'b1, wide_payload_select)
    `CHK("surround_enable", 1'b1, surround_enable)
    `CHK("data_island_transport", 1'b1, data_island_transport)
    wr(8'h1a, 8'h00);
    wait_n(3);
    `CHK("surround_enable", 1'b0, surround_enable)
    inband_override_disable = 0;
    inband_surround_detect = 1;
    wait_n(3);
    `CHK("surround_enable", 1'b1, surround_enable)
    inband_surround_detect = 0;
    $display("test dp done");
  endtask
  task automatic t_master();
    wr(8'h18, 8'h02);
    wr(8'h19, 8'h03);
    master_active = 1;
    span(master_scl_drive, 1'b0, n);
    span(master_scl_drive, 1'b1, n);
    `CHK("low cycles", 8, n)
    span(master_scl_drive, 1'b0, n);
    `CHK("high cycles", 7, n)
    master_active = 0;
    target_stretch_req = 1;
    span(target_scl_release, 1'b1, n);
    span(target_scl_release, 1'b0, n);
    `CHK("setup cycles", 3, n)
    target_stretch_req = 0;
    $display("test master done");
  endtask
  task automatic t_pins();
    wr(8'h17, 8'h70);
    host_sda_low = 1;
    wait_n(7);
    `CHK("sda_sampled", 1'b1, sda_sampled)
    wait_n(1);
    `CHK("sda_sampled", 1'b0, sda_sampled)
    host_sda_low = 0;
    host_scl_low = 1;
    wait_n(1);
    host_scl_low = 0;
    wait_n(4);
    `CHK("scl_filtered", 1'b1, scl_filtered)
    host_scl_low = 1;
    wait_n(10);
    `CHK("scl_filtered", 1'b0, scl_filtered)
    host_scl_low = 0;
    wait_n(12);
    `CHK("sda_sampled", 1'b1, sda_sampled)
    $display("test pins done");
  endtask
  initial begin
    {reg_write, reg_read, access_valid, master_active, target_stretch_req} = 5'h00;
    {second_port_select, inband_surround_detect, inband_override_disable} = 3'h0;
    {host_scl_low, host_sda_low, reg_addr, reg_wdata, access_target_id} = 25'h0;
    own_target_id = 7'h10;
    remote_deser_id = 7'h20;
    remote_target_id = 7'h21;
    aux_audio_control = 1;
    rst = 1;
    repeat (8) @(posedge clk_sys);
    #5 rst = 0;
    t_reset_vals();
    t_fwd();
    t_dp();
    t_master();
    t_pins();
    close_out();
  end
endmodule
